// *** hw/arsq_defines.svh ***
// timing constants and state codes for the autorange rectifier sequencer
`ifndef ARSQ_DEFINES_SVH
`define ARSQ_DEFINES_SVH
`define CLK_FREQ_HZ       200000000
`define ENABLE_DELAY_MS   150
`define BUSGOOD_DELAY_MS  150
`define DELAY_CYCLES(ms)  ((`CLK_FREQ_HZ / 1000) * (ms))
`define ST_OFF            6'h01
`define ST_CHARGE         6'h02
`define ST_BYPASS         6'h04
`define ST_ENWAIT         6'h08
`define ST_GOODWAIT       6'h10
`define ST_RUN            6'h20
`endif

// *** hw/arsq_pkg.sv ***
// types shared by the rectifier sequencer files
`default_nettype none
`include "arsq_defines.svh"
package arsq_pkg;
	typedef enum logic [5:0]
	{
		stOff      = `ST_OFF,
		stCharge   = `ST_CHARGE,
		stBypass   = `ST_BYPASS,
		stEnWait   = `ST_ENWAIT,
		stGoodWait = `ST_GOODWAIT,
		stRun      = `ST_RUN
	} seq_state_t;

	// bus comparator results, all already synchronous to clk
	typedef struct packed
	{
		logic above400;
		logic above235;
		logic above205;
		logic above200;
		logic above180;
		logic slopeSettled;
		logic powerPresent;
	} bus_sense_t;

	// pin drive levels; high on a switch pin means switch on (active high)
	typedef struct packed
	{
		logic bypassClosed;
		logic doublerOn;
		logic convEnable;
		logic busGoodHigh;
	} seq_out_t;
endpackage
`default_nettype wire

// *** hw/autorange_rectifier_sequencer.sv ***
// power-up and power-down sequencer for an autoranging rectifier front end
`timescale 1ns/1ps
`default_nettype none
`include "arsq_defines.svh"
// Function
// - both switches open at power application
// - enable off, bus-good high until released
// - settled slope: doubler on below 200 V
// - settled slope: bypass closes above 235 V
// - enable converters 150 ms after bypass
// - bus-good asserted further 150 ms later
// - bus-good deasserted below 205 V
// - converters disabled below 200 V
// - power back after disable restarts sequence
// - early power return keeps present states
// - above 400 V: disable, open bypass
// - below 180 V: open bypass
// - bus-good low normal, high abnormal
// - enable low disables, high enables
module autorange_rectifier_sequencer
	import arsq_pkg::*;
#(
	parameter int unsigned ENABLE_CYCLES  = `DELAY_CYCLES(`ENABLE_DELAY_MS),
	parameter int unsigned BUSGOOD_CYCLES = `DELAY_CYCLES(`BUSGOOD_DELAY_MS)
)
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire bus_sense_t sense,
	output seq_out_t        pins,
	output seq_state_t      seqState
);
	// ************************************************************
	// state
	// ************************************************************
	seq_state_t state_ff;
	seq_state_t nxt_state;
	seq_out_t   out_ff;
	seq_out_t   nxt_out;
	logic       enDone;
	logic       goodDone;

	// refused at elaboration: a zero delay would let the enable race the bypass
	if (ENABLE_CYCLES < 1 || BUSGOOD_CYCLES < 1)
	begin : g_bad_delay
		$error("sequencer delays must be at least one cycle");
	end

	// ************************************************************
	// delay timers
	// ************************************************************
	// both delays count whole clocks; inputs arrive synchronous
	delay_timer #(.CYCLES(ENABLE_CYCLES)) enTimer
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.run     (state_ff == stEnWait),
		.done    (enDone)
	);

	delay_timer #(.CYCLES(BUSGOOD_CYCLES)) goodTimer
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.run     (state_ff == stGoodWait),
		.done    (goodDone)
	);

	// ************************************************************
	// sequencing
	// ************************************************************
	// next state and pin levels; protection terms override the sequence
	always_comb
	begin
		nxt_state = state_ff;
		nxt_out   = out_ff;
		case (state_ff)
			stOff:
			begin
				nxt_out = '{bypassClosed: 1'b0, doublerOn: 1'b0,
					convEnable: 1'b0, busGoodHigh: 1'b1};
				if (sense.powerPresent)
					nxt_state = stCharge;
			end
			stCharge:
			begin
				// doubler picked first; bypass waits a cycle on the new range
				if (sense.slopeSettled)
				begin
					nxt_out.doublerOn = !sense.above200;
					nxt_state = stBypass;
				end
			end
			stBypass:
			begin
				// no timeout: a low bus here waits until it settles above 235 V
				if (sense.slopeSettled && sense.above235 && !sense.above400)
				begin
					nxt_out.bypassClosed = 1'b1;
					nxt_state = stEnWait;
				end
			end
			stEnWait:
			begin
				if (enDone)
				begin
					nxt_out.convEnable = 1'b1;
					nxt_state = stGoodWait;
				end
			end
			stGoodWait:
			begin
				if (goodDone)
				begin
					nxt_out.busGoodHigh = 1'b0;
					nxt_state = stRun;
				end
			end
			stRun:
			begin
				// power returning here changes nothing, sequence is not rerun
				nxt_state = stRun;
			end
			default:
			begin
				nxt_state = stOff;
			end
		endcase
		if (state_ff != stOff)
		begin
			if (!sense.above205)
				nxt_out.busGoodHigh = 1'b1;
			if (!sense.above200 && out_ff.convEnable)
			begin
				nxt_out.convEnable = 1'b0;
				nxt_out.busGoodHigh = 1'b1;
				nxt_state = stOff;
			end
			if (sense.above400)
			begin
				nxt_out.convEnable = 1'b0;
				nxt_out.bypassClosed = 1'b0;
				nxt_out.busGoodHigh = 1'b1;
				nxt_state = stOff;
			end
			if (!sense.above180 && out_ff.bypassClosed)
			begin
				nxt_out.bypassClosed = 1'b0;
				nxt_out.convEnable = 1'b0;
				nxt_out.busGoodHigh = 1'b1;
				nxt_state = stOff;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_ff <= stOff;
			out_ff   <= '{bypassClosed: 1'b0, doublerOn: 1'b0,
				convEnable: 1'b0, busGoodHigh: 1'b1};
		end
		else
		begin
			state_ff <= nxt_state;
			out_ff   <= nxt_out;
		end
	end

	assign pins     = out_ff;
	assign seqState = state_ff;

	// ************************************************************
	// check helpers
	// ************************************************************
	logic [31:0] bypassAge_ff;
	logic [31:0] nxt_bypassAge;

	// clocks since the bypass closed, kept apart from the timers so
	// the delay checks do not trust the counters they are watching
	always_comb
	begin
		nxt_bypassAge = bypassAge_ff;
		if (state_ff == stEnWait || state_ff == stGoodWait)
			nxt_bypassAge = bypassAge_ff + 32'h1;
		else if (state_ff != stRun)
			nxt_bypassAge = '0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			bypassAge_ff <= '0;
		else
			bypassAge_ff <= nxt_bypassAge;
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_reset_safe: assert property (@(posedge clk) $past(sys_rst) |->
		(!pins.bypassClosed && !pins.doublerOn)) else $error("switches not open after reset");
	a_reset_outs: assert property (@(posedge clk) $past(sys_rst) |->
		(!pins.convEnable && pins.busGoodHigh)) else $error("outputs not safe after reset");
	a_doubler_pick: assert property (@(posedge clk) disable iff (sys_rst)
		(state_ff == stCharge && sense.slopeSettled && !sense.above400 && sense.above180)
		|=> (pins.doublerOn == !$past(sense.above200))) else $error("doubler decision wrong");
	a_bypass_level: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(pins.bypassClosed) |-> $past(sense.above235)) else $error("bypass closed low");
	a_enable_delay: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(pins.convEnable) |-> $past(state_ff == stEnWait)) else $error("enable early");
	a_enable_time: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(pins.convEnable) |-> (bypassAge_ff == ENABLE_CYCLES + 32'h1))
		else $error("enable delay off count");
	a_good_time: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(pins.busGoodHigh) |-> (bypassAge_ff == ENABLE_CYCLES + BUSGOOD_CYCLES + 32'h2))
		else $error("bus good delay off count");
	a_good_after: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(pins.busGoodHigh) |-> pins.convEnable) else $error("bus good before enable");
	a_good_drop: assert property (@(posedge clk) disable iff (sys_rst)
		(!sense.above205 && state_ff != stOff) |=> pins.busGoodHigh) else $error("bus good kept");
	a_enable_drop: assert property (@(posedge clk) disable iff (sys_rst)
		(!sense.above200 && pins.convEnable) |=> !pins.convEnable) else $error("enable kept");
	a_over_volt: assert property (@(posedge clk) disable iff (sys_rst)
		(sense.above400 && state_ff != stOff) |=> (!pins.convEnable && !pins.bypassClosed))
		else $error("overvoltage not handled");
	a_under_volt: assert property (@(posedge clk) disable iff (sys_rst)
		(!sense.above180 && pins.bypassClosed) |=> !pins.bypassClosed) else $error("bypass kept");
endmodule
`default_nettype wire

// *** hw/delay_timer.sv ***
// one-shot cycle counter that flags expiry of a fixed delay
`timescale 1ns/1ps
`default_nettype none
`include "arsq_defines.svh"
module delay_timer
#(
	parameter int unsigned CYCLES = `DELAY_CYCLES(`ENABLE_DELAY_MS)
)
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic run,
	output logic      done
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] count_ff;
	logic [W-1:0] nxt_count;

	// refused at elaboration: a zero count would never leave its first state
	if (CYCLES < 1)
	begin : g_bad_cycles
		$error("delay_timer needs at least one cycle");
	end

	// counts while run is held and stops at CYCLES; clears on the first edge after run drops
	always_comb
	begin
		nxt_count = count_ff;
		if (!run)
			nxt_count = '0;
		else if (count_ff != W'(CYCLES))
			nxt_count = count_ff + W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			count_ff <= '0;
		else
			count_ff <= nxt_count;
	end

	assign done = run && (count_ff == W'(CYCLES));
endmodule
`default_nettype wire

// *** test/converter_load_model.sv ***
// behavioural model of the downstream converters and the power-fail monitor
`timescale 1ns/1ps
`default_nettype none
module converter_load_model
(
	input  wire logic clk,
	input  wire logic convEnable,
	input  wire logic busGoodHigh,
	output logic      convRunning,
	output logic      powerFailWarn
);
	// converters start one cycle after the enable line is released high;
	// a real gate-in pin has no latch, so the model holds none either
	always_ff @(posedge clk)
	begin
		convRunning <= convEnable;
	end
	// the monitor reads a high bus-good line as an impending power failure
	assign powerFailWarn = busGoodHigh;
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the autorange rectifier sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench
	import arsq_pkg::*;
;
	localparam int unsigned EN_CYC   = 20;
	localparam int unsigned GOOD_CYC = 20;
	logic       clk;
	logic       sysRst;
	bus_sense_t sense;
	seq_out_t   pins;
	seq_state_t seqState;
	logic       convRunning;
	logic       powerFailWarn;
	int         badCount;
	int         checkCount;
	int         cycleCount;

	autorange_rectifier_sequencer #(.ENABLE_CYCLES(EN_CYC), .BUSGOOD_CYCLES(GOOD_CYC))
		i_autorange_rectifier_sequencer
		(.clk(clk), .sys_rst(sysRst), .sense(sense), .pins(pins), .seqState(seqState));
	converter_load_model i_converter_load_model
		(.clk(clk), .convEnable(pins.convEnable), .busGoodHigh(pins.busGoodHigh),
		 .convRunning(convRunning), .powerFailWarn(powerFailWarn));

	// ****************************************
	// clock, timeout and shared tasks
	// ****************************************
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	// generous ceiling: the whole sequence needs well under 300 cycles
	always @(posedge clk)
	begin
		cycleCount <= cycleCount + 1;
		if (cycleCount == 2000)
		begin
			badCount = badCount + 1;
			closeOut();
		end
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checkCount = checkCount + 1;
		if (seen !== exp)
		begin
			badCount = badCount + 1;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// drive a new sense word on an edge, then look n edges later once settled
	task automatic apply(input logic [6:0] v, input int n);
		@(posedge clk);
		sense <= bus_sense_t'(v);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic tickN(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic closeOut();
		if (badCount == 0 && checkCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	// sense bits: 01 power, 02 settled, 04 >180, 08 >200, 10 >205, 20 >235, 40 >400
	initial
	begin
		sysRst = 1'b1;
		sense = bus_sense_t'(7'h00);
		badCount = 0;
		checkCount = 0;
		cycleCount = 0;
		repeat (2) @(posedge clk);
		sysRst <= 1'b0;
		#1;
		chk("pins", 8'(pins), 8'h01);
		chk("state", 8'(seqState), 8'(stOff));
		// low line: doubler engages, bypass waits for 235 V
		apply(7'h01, 1);
		chk("pins", 8'(pins), 8'h01);
		apply(7'h07, 1);
		chk("pins", 8'(pins), 8'h05);
		chk("state", 8'(seqState), 8'(stBypass));
		apply(7'h1f, 1);
		chk("pins", 8'(pins), 8'h05);
		apply(7'h3f, 1);
		chk("pins", 8'(pins), 8'h0d);
		tickN(EN_CYC);
		chk("pins", 8'(pins), 8'h0d);
		tickN(1);
		chk("pins", 8'(pins), 8'h0f);
		tickN(GOOD_CYC);
		chk("pins", 8'(pins), 8'h0f);
		tickN(1);
		chk("pins", 8'(pins), 8'h0e);
		chk("state", 8'(seqState), 8'(stRun));
		chk("load", 8'({convRunning, powerFailWarn}), 8'h02);
		// power loss, momentary return, then decay past disable
		apply(7'h1c, 1);
		chk("pins", 8'(pins), 8'h0e);
		apply(7'h0c, 1);
		chk("pins", 8'(pins), 8'h0f);
		apply(7'h0f, 2);
		chk("pins", 8'(pins), 8'h0f);
		chk("state", 8'(seqState), 8'(stRun));
		apply(7'h04, 1);
		chk("enable", 8'(pins.convEnable), 8'h00);
		chk("state", 8'(seqState), 8'(stOff));
		apply(7'h01, 2);
		chk("pins", 8'(pins), 8'h01);
		chk("state", 8'(seqState), 8'(stCharge));
		// high line: no doubler, then overvoltage
		apply(7'h1f, 1);
		chk("pins", 8'(pins), 8'h01);
		apply(7'h3f, 1);
		chk("pins", 8'(pins), 8'h09);
		tickN(EN_CYC + 1);
		chk("pins", 8'(pins), 8'h0b);
		apply(7'h7f, 1);
		chk("pins", 8'(pins), 8'h01);
		chk("state", 8'(seqState), 8'(stOff));
		// restart, then a fault pulls the bus under 180 V
		apply(7'h3f, 3);
		chk("pins", 8'(pins), 8'h09);
		apply(7'h3b, 1);
		chk("pins", 8'(pins), 8'h01);
		chk("state", 8'(seqState), 8'(stOff));
		closeOut();
	end
endmodule
`default_nettype wire
